// >>> verilog/ixr_slave.sv
// Purpose: slave end giving register access over the two-wire link
// Assumes: register file outside, one byte per access, combinational read
// Notes: link pins are sampled by the 40 MHz clock
`timescale 1ns/1ps
`include "ixr_params.svh"
module ixr_slave (
   input wire logic clock,
   input wire logic rst_b,
   ixr_link_if.slave link,
   input wire logic addr_strap_bit_low,
   input wire logic addr_strap_bit_high,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   output logic soft_reset,
   output logic busy
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic scl_m_q, scl_q, scl_p_q, sda_m_q, sda_q, sda_p_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         scl_m_q <= 1'b1;
         scl_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= link.scl;
         scl_q <= scl_m_q;
         scl_p_q <= scl_q;
         sda_m_q <= link.serial_data_line;
         sda_q <= sda_m_q;
         sda_p_q <= sda_q;
      end
   end
   logic start_ev, stop_ev, scl_rise, scl_fall;
   assign start_ev = scl_q && scl_p_q && sda_p_q && !sda_q;
   assign stop_ev = scl_q && scl_p_q && !sda_p_q && sda_q;
   assign scl_rise = scl_q && !scl_p_q;
   assign scl_fall = !scl_q && scl_p_q;

   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   logic rst_seen_q, latch_req_q;
   logic [1:0] strap_q;
   logic [7:0] my_addr;
   logic [1:0] strap_m_q, strap_s_q;
   // no reset here: levels held during reset are through both stages
   // by the time the capture fires
   always_ff @(posedge clock) begin
      strap_m_q <= {addr_strap_bit_high, addr_strap_bit_low};
      strap_s_q <= strap_m_q;
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_seen_q <= 1'b1;
         strap_q <= 2'h0;
      end else begin
         rst_seen_q <= 1'b0;
         // caught once after release, or on a general call reset or latch byte
         if (rst_seen_q || latch_req_q) begin
            strap_q <= strap_s_q;
         end
      end
   end
   always_comb begin
      case (strap_q)
         2'b00: my_addr = `IXR_ADDR_00;
         2'b01: my_addr = `IXR_ADDR_01;
         2'b10: my_addr = `IXR_ADDR_10;
         default: my_addr = `IXR_ADDR_11;
      endcase
   end

   // ----------------------------------------
   // byte engine
   // ----------------------------------------
   ixr_pkg::ixr_slv_state_type st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q, ptr_q, tx_q;
   logic ack_slot_q, rd_nak_q, drive_q, sda_out_q, tx_ack_q, adv_q;
   logic [7:0] rx;
   assign rx = {sh_q[6:0], sda_q};

   // pointer step: only pwm data port window 0x38-0x3F stays fixed
   function automatic logic [7:0] ixr_next_ptr(input logic [7:0] p);
      if (p[7:3] == 5'h07) ixr_next_ptr = p;
      else ixr_next_ptr = p + 8'h01;
   endfunction

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ixr_pkg::IXR_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         tx_q <= 8'h00;
         ack_slot_q <= 1'b0;
         rd_nak_q <= 1'b0;
         tx_ack_q <= 1'b0;
         adv_q <= 1'b0;
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         reg_wdata <= 8'h00;
         latch_req_q <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         latch_req_q <= 1'b0;
         soft_reset <= 1'b0;
         if (start_ev) begin
            st_q <= ixr_pkg::IXR_ADDR;
            bit_q <= 4'h0;
            ack_slot_q <= 1'b0;
         end else if (stop_ev) begin
            st_q <= ixr_pkg::IXR_IDLE;
            ack_slot_q <= 1'b0;
         end else if (st_q != ixr_pkg::IXR_IDLE && scl_rise) begin
            if (ack_slot_q) begin
               // ninth clock: master ack on read decides continuation
               rd_nak_q <= sda_q;
            end else begin
               sh_q <= rx;
               bit_q <= bit_q + 4'h1;
            end
         end else if (st_q != ixr_pkg::IXR_IDLE && scl_fall) begin
            if (ack_slot_q) begin
               ack_slot_q <= 1'b0;
               bit_q <= 4'h0;
               // only the master's slot after a sent byte continues a read
               if (tx_ack_q) begin
                  if (rd_nak_q) st_q <= ixr_pkg::IXR_SKIP;
                  else begin
                     tx_q <= reg_rdata;
                     reg_rd <= 1'b1;
                     ptr_q <= ixr_next_ptr(ptr_q);
                  end
               end else if (adv_q) begin
                  // step after the slot so reg_addr holds during reg_wr
                  ptr_q <= ixr_next_ptr(ptr_q);
               end
            end else if (bit_q == 4'h8) begin
               ack_slot_q <= 1'b1;
               tx_ack_q <= (st_q == ixr_pkg::IXR_RDAT);
               adv_q <= (st_q == ixr_pkg::IXR_WDAT);
               case (st_q)
                  ixr_pkg::IXR_ADDR: begin
                     if (sh_q == 8'h00) begin
                        st_q <= ixr_pkg::IXR_GCB;
                     end else if (sh_q[7:1] == my_addr[7:1]) begin
                        if (sh_q[0]) begin
                           st_q <= ixr_pkg::IXR_RDAT;
                           tx_q <= reg_rdata;
                           reg_rd <= 1'b1;
                           ptr_q <= ixr_next_ptr(ptr_q);
                        end else st_q <= ixr_pkg::IXR_PTR;
                     end else if (sh_q[7:3] == `IXR_TENBIT_HDR &&
                        sh_q[2:1] == 2'b00 && !sh_q[0]) begin
                        st_q <= ixr_pkg::IXR_ADDR2;
                     end else begin
                        st_q <= ixr_pkg::IXR_SKIP;
                        ack_slot_q <= 1'b0;
                     end
                  end
                  ixr_pkg::IXR_ADDR2: begin
                     if (sh_q == my_addr) st_q <= ixr_pkg::IXR_PTR;
                     else begin
                        st_q <= ixr_pkg::IXR_SKIP;
                        ack_slot_q <= 1'b0;
                     end
                  end
                  ixr_pkg::IXR_PTR: begin
                     ptr_q <= sh_q;
                     st_q <= ixr_pkg::IXR_WDAT;
                  end
                  ixr_pkg::IXR_WDAT: begin
                     reg_wdata <= sh_q;
                     reg_wr <= 1'b1;
                  end
                  ixr_pkg::IXR_GCB: begin
                     st_q <= ixr_pkg::IXR_SKIP;
                     if (sh_q == `IXR_GC_RESET) begin
                        soft_reset <= 1'b1;
                        latch_req_q <= 1'b1;
                     end else if (sh_q == `IXR_GC_LATCH) begin
                        latch_req_q <= 1'b1;
                     end
                  end
                  ixr_pkg::IXR_RDAT: ack_slot_q <= 1'b1;
                  default: ack_slot_q <= 1'b0;
               endcase
            end
         end
      end
   end

   // ----------------------------------------
   // data pin drive, changed on clock low, released on start or stop
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         drive_q <= 1'b0;
         sda_out_q <= 1'b1;
      end else if (start_ev || stop_ev) begin
         drive_q <= 1'b0;
      end else if (!scl_q) begin
         if (ack_slot_q && !tx_ack_q) begin
            drive_q <= 1'b1;
            sda_out_q <= 1'b0;
         end else if (st_q == ixr_pkg::IXR_RDAT && !ack_slot_q &&
            bit_q < 4'h8) begin
            drive_q <= !tx_q[3'h7 - bit_q[2:0]];
            sda_out_q <= 1'b0;
         end else begin
            drive_q <= 1'b0;
            sda_out_q <= 1'b1;
         end
      end
   end
   assign link.sda_oe_s = drive_q;
   assign link.sda_o_s = sda_out_q;
   assign reg_addr = ptr_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) busy <= 1'b0;
      else busy <= (st_q != ixr_pkg::IXR_IDLE);
   end
endmodule // ixr_slave

// >>> verilog/ixr_params.svh
// Purpose: shared constants for the two-wire register access link
// Assumes: both ends run on a 40 MHz system clock
// Notes: timing counts derive from printed bit rates
// Functional notes
// - every register is one byte wide
// - power and interrupt ranges auto-increment pointer
// - pwm low eight increment, upper eight fixed
// - keypad, rotator, gpio ranges auto-increment
// - slave only, standard and fast rates
// - seven-bit, ten-bit and general call accepted; the slave takes a ten-bit header only with the write bit, so no ten-bit read
// - strap pins sampled at reset and again on general call 0x06 or 0x04
// - start is data falling with clock high
// - nothing answered until a start is seen
// - stop is data rising with clock high
// - stop after not_acknowledge returns to idle
// - stop ends register writing
// - transmitter releases data after eight bits
// - receiver pulls data low in ninth clock
// - direction bit; ack only on address match
// - master writes pointer, restarts, then reads
// - general call 0x06 resets, 0x04 relatches
`ifndef IXR_PARAMS_SVH
`define IXR_PARAMS_SVH
`define IXR_ADDR_00 8'h84
`define IXR_ADDR_01 8'h86
`define IXR_ADDR_10 8'h88
`define IXR_ADDR_11 8'h8A
`define IXR_TENBIT_HDR 5'h1E
`define IXR_GC_RESET 8'h06
`define IXR_GC_LATCH 8'h04
`define IXR_CLK_MHZ 40
`define IXR_BIT_NS_STD 10000
`define IXR_BIT_NS_FAST 2500
`define IXR_HALF_STD ((`IXR_BIT_NS_STD*`IXR_CLK_MHZ)/2000)
`define IXR_HALF_FAST ((`IXR_BIT_NS_FAST*`IXR_CLK_MHZ)/2000)
`endif

// >>> verilog/ixr_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes: states only
package ixr_pkg;
   typedef enum logic [2:0] {
      IXR_IDLE, IXR_ADDR, IXR_ADDR2, IXR_PTR, IXR_WDAT, IXR_RDAT, IXR_GCB,
      IXR_SKIP
   } ixr_slv_state_type;
   typedef enum logic [2:0] {
      IXR_M_IDLE, IXR_M_START, IXR_M_BIT, IXR_M_ACK, IXR_M_STOP,
      IXR_M_RSTART
   } ixr_mst_state_type;
endpackage

// >>> verilog/ixr_link_if.sv
// Purpose: two-wire link joining master and slave ends
// Assumes: open-drain wires with pull-up resolved here
// Notes: no clocking block
`timescale 1ns/1ps
interface ixr_link_if;
   logic scl_o_m;
   logic scl_oe_m;
   logic sda_o_m;
   logic sda_oe_m;
   logic sda_o_s;
   logic sda_oe_s;
   logic scl;
   logic serial_data_line;
   // wired-and with pull-up
   assign scl = !(scl_oe_m && !scl_o_m);
   assign serial_data_line = !((sda_oe_m && !sda_o_m) ||
      (sda_oe_s && !sda_o_s));
   modport master (output scl_o_m, output scl_oe_m, output sda_o_m,
      output sda_oe_m, input scl, input serial_data_line);
   modport slave (output sda_o_s, output sda_oe_s, input scl,
      input serial_data_line);
endinterface

// >>> verilog/ixr_master.sv
// Purpose: master end issuing byte transfers on the two-wire link
// Assumes: user asks one byte at a time with start/stop flags
// Notes: link clock made by dividing the system clock
`timescale 1ns/1ps
`include "ixr_params.svh"
module ixr_master #(
   parameter int HALF_CYC = `IXR_HALF_STD
) (
   input wire logic clock,
   input wire logic rst_b,
   ixr_link_if.master link,
   input wire logic cmd_valid,
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire logic cmd_read,
   input wire logic cmd_nak,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   output logic done,
   output logic got_ack,
   output logic [7:0] rd_data
);
   ixr_pkg::ixr_mst_state_type st_q;
   logic [15:0] cnt_q;
   logic ph_q, scl_q, sda_q, rd_q, nak_q, stop_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic sda_m_q, sda_s_q;
   logic tick;
   assign tick = (cnt_q == 16'(HALF_CYC - 1));
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         sda_m_q <= link.serial_data_line;
         sda_s_q <= sda_m_q;
      end
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) cnt_q <= 16'h0000;
      else if (st_q == ixr_pkg::IXR_M_IDLE || tick) cnt_q <= 16'h0000;
      else cnt_q <= cnt_q + 16'h0001;
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ixr_pkg::IXR_M_IDLE;
         ph_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         rd_q <= 1'b0;
         nak_q <= 1'b0;
         stop_q <= 1'b0;
         cmd_ready <= 1'b1;
         done <= 1'b0;
         got_ack <= 1'b0;
         rd_data <= 8'h00;
      end else begin
         done <= 1'b0;
         case (st_q)
            ixr_pkg::IXR_M_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  sh_q <= cmd_data;
                  rd_q <= cmd_read;
                  nak_q <= cmd_nak;
                  stop_q <= cmd_stop;
                  bit_q <= 4'h0;
                  ph_q <= 1'b0;
                  if (cmd_start) begin
                     st_q <= scl_q ? ixr_pkg::IXR_M_START :
                        ixr_pkg::IXR_M_RSTART;
                  end else st_q <= ixr_pkg::IXR_M_BIT;
               end
            end
            ixr_pkg::IXR_M_RSTART: if (tick) begin
               // lift data, then clock, before a repeated start
               if (!ph_q) sda_q <= 1'b1;
               else begin
                  scl_q <= 1'b1;
                  st_q <= ixr_pkg::IXR_M_START;
               end
               ph_q <= !ph_q;
            end
            ixr_pkg::IXR_M_START: if (tick) begin
               if (!ph_q) sda_q <= 1'b0;
               else begin
                  scl_q <= 1'b0;
                  st_q <= ixr_pkg::IXR_M_BIT;
               end
               ph_q <= !ph_q;
            end
            ixr_pkg::IXR_M_BIT: if (tick) begin
               if (!ph_q) begin
                  sda_q <= rd_q ? 1'b1 : sh_q[7];
                  scl_q <= 1'b1;
               end else begin
                  sh_q <= {sh_q[6:0], sda_s_q};
                  scl_q <= 1'b0;
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'h7) st_q <= ixr_pkg::IXR_M_ACK;
               end
               ph_q <= !ph_q;
            end
            ixr_pkg::IXR_M_ACK: if (tick) begin
               if (!ph_q) begin
                  sda_q <= rd_q ? nak_q : 1'b1;
                  scl_q <= 1'b1;
               end else begin
                  got_ack <= !sda_s_q;
                  rd_data <= sh_q;
                  scl_q <= 1'b0;
                  // let go of our own ack so the next read bit is free
                  sda_q <= 1'b1;
                  if (stop_q) st_q <= ixr_pkg::IXR_M_STOP;
                  else begin
                     st_q <= ixr_pkg::IXR_M_IDLE;
                     cmd_ready <= 1'b1;
                     done <= 1'b1;
                  end
               end
               ph_q <= !ph_q;
            end
            ixr_pkg::IXR_M_STOP: if (tick) begin
               if (!ph_q) begin
                  sda_q <= 1'b0;
                  scl_q <= 1'b1;
               end else begin
                  sda_q <= 1'b1;
                  st_q <= ixr_pkg::IXR_M_IDLE;
                  cmd_ready <= 1'b1;
                  done <= 1'b1;
               end
               ph_q <= !ph_q;
            end
            default: st_q <= ixr_pkg::IXR_M_IDLE;
         endcase
      end
   end
   assign link.scl_o_m = scl_q;
   assign link.scl_oe_m = !scl_q;
   assign link.sda_o_m = sda_q;
   assign link.sda_oe_m = !sda_q;
endmodule // ixr_master

// >>> test/ixr_link_monitor.sv
// Purpose: wire-level checks of the two-wire link
// Assumes: one master end and one slave end on the link
// Notes: byte slots found by counting clock rises since start
`timescale 1ns/1ps
module ixr_link_monitor (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic serial_data_line,
   input wire logic sda_o_m,
   input wire logic sda_oe_m,
   input wire logic sda_o_s,
   input wire logic sda_oe_s
);
   logic s_low, m_low, scl_q, sda_q, seen_q, rd_q, first_q;
   logic [3:0] cnt_q;
   assign s_low = sda_oe_s && !sda_o_s;
   assign m_low = sda_oe_m && !sda_o_m;
   // -------------------------------------------
   // helper state
   // -------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= serial_data_line;
      end
   end
   // direction is the eighth bit of the first byte after a start
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         seen_q <= 1'b0;
         cnt_q <= 4'h0;
         rd_q <= 1'b0;
         first_q <= 1'b1;
      end else if (scl && scl_q && sda_q && !serial_data_line) begin
         seen_q <= 1'b1;
         cnt_q <= 4'h0;
         first_q <= 1'b1;
      end else if (scl && !scl_q) begin
         if (cnt_q == 4'h8) begin
            cnt_q <= 4'h0;
            first_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
         if (cnt_q == 4'h7 && first_q) begin
            rd_q <= serial_data_line;
         end
      end
   end
   // -------------------------------------------
   // assertions
   // -------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence start_s;
      scl && $past(scl) && $fell(serial_data_line);
   endsequence
   sequence stop_s;
      scl && $past(scl) && $rose(serial_data_line);
   endsequence
   sequence ack_slot_s;
      $rose(scl) && cnt_q == 4'h8;
   endsequence
   sda_change_low_a: assert property (
      $changed(s_low) |-> !scl)
      else $error("slave data drive changed with clock high");
   drive_begin_a: assert property (
      $rose(s_low) |-> !scl && !$past(scl))
      else $error("slave drive began too near a clock edge");
   stop_quiet_a: assert property (
      stop_s |=> (!s_low) [*8])
      else $error("slave drove data after stop");
   before_start_a: assert property (
      !seen_q |-> !s_low)
      else $error("slave drove data before any start");
   slave_ack_slot_a: assert property (
      $rose(scl) && s_low && !rd_q |-> cnt_q == 4'h8)
      else $error("slave drove low outside the ninth bit");
   read_ack_free_a: assert property (
      ack_slot_s ##0 (rd_q && !first_q) |-> !s_low)
      else $error("slave held data in read ack slot");
   write_ack_free_a: assert property (
      ack_slot_s ##0 !rd_q |-> !m_low)
      else $error("master held data in write ack slot");
   restart_quiet_a: assert property (
      start_s |-> (!s_low) [*8])
      else $error("slave drove data right after start");
endmodule // ixr_link_monitor

// >>> test/tb_top.sv
// Purpose: self-checking bench for the master and slave ends
// Assumes: reg_rdata is a fixed function of reg_addr
// Notes: half bit cut to 20 cycles to keep the run short
`timescale 1ns/1ps
`include "ixr_params.svh"
module tb_top;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic addr_strap_bit_low = 1'b0, addr_strap_bit_high = 1'b0;
   logic cmd_valid = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0;
   logic cmd_read = 1'b0, cmd_nak = 1'b0;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ready, done, got_ack, reg_wr, reg_rd, soft_reset, busy;
   logic [7:0] rd_data, reg_addr, reg_wdata, reg_rdata, cur;
   logic [15:0] wq[$], eq[$];
   logic [7:0] ptrs[8] = '{8'h05, 8'h1C, 8'h36, 8'h3D, 8'h6C, 8'h74,
      8'h80, 8'hBC};
   logic [7:0] gcb[3] = '{8'h05, `IXR_GC_LATCH, `IXR_GC_RESET};
   logic [1:0] gns[3] = '{2'h1, 2'h1, 2'h2};
   logic [1:0] gex[3] = '{2'h3, 2'h1, 2'h2};
   int errors = 0;
   int checks = 0;
   int gc_pulses = 0;
   int rd_pulses = 0;
   always #12.5 clock = ~clock;
   ixr_link_if link ();
   ixr_master #(.HALF_CYC(20)) u_ixr_master (.clock(clock), .rst_b(rst_b),
      .link(link), .cmd_valid(cmd_valid), .cmd_start(cmd_start),
      .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nak(cmd_nak),
      .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done),
      .got_ack(got_ack), .rd_data(rd_data));
   ixr_slave u_ixr_slave (.clock(clock), .rst_b(rst_b), .link(link),
      .addr_strap_bit_low(addr_strap_bit_low),
      .addr_strap_bit_high(addr_strap_bit_high), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .soft_reset(soft_reset), .busy(busy));
   ixr_link_monitor u_ixr_link_monitor (.clock(clock), .rst_b(rst_b),
      .scl(link.scl), .serial_data_line(link.serial_data_line),
      .sda_o_m(link.sda_o_m), .sda_oe_m(link.sda_oe_m),
      .sda_o_s(link.sda_o_s), .sda_oe_s(link.sda_oe_s));
   assign reg_rdata = rdat(reg_addr);
   // -------------------------------------------
   // expectations and helpers
   // -------------------------------------------
   function automatic logic [7:0] rdat(input logic [7:0] a);
      return a ^ 8'hA5;
   endfunction
   // upper pwm locations keep the pointer fixed
   function automatic logic [7:0] nxt(input logic [7:0] p);
      return (p >= 8'h38 && p <= 8'h3F) ? p : p + 8'h01;
   endfunction
   function automatic logic [7:0] sadr(input logic [1:0] s);
      if (s[1]) return s[0] ? `IXR_ADDR_11 : `IXR_ADDR_10;
      return s[0] ? `IXR_ADDR_01 : `IXR_ADDR_00;
   endfunction
   always @(negedge clock) begin
      if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
      if (soft_reset === 1'b1) gc_pulses++;
      if (reg_rd === 1'b1) rd_pulses++;
   end
   task automatic chk(input string what, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic xfer(input logic st, sp, rd, nk, input logic [7:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 4000) begin
         @(negedge clock);
         n++;
      end
      {cmd_start, cmd_stop, cmd_read, cmd_nak} = {st, sp, rd, nk};
      cmd_data = d;
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      while (done !== 1'b1 && n < 4000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 4000) begin
         errors++;
         give_verdict();
      end
   endtask
   task automatic wr_seq(input logic [7:0] adr, p, input int n,
      input logic sp, ten);
      logic [7:0] d;
      wq.delete();
      eq.delete();
      cur = p;
      if (ten) begin
         xfer(1'b1, 1'b0, 1'b0, 1'b0, {`IXR_TENBIT_HDR, 3'h0});
         chk("header ack", 16'(got_ack), 16'h0001);
      end
      xfer(!ten, 1'b0, 1'b0, 1'b0, adr);
      chk("address ack", 16'(got_ack), 16'h0001);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, p);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         xfer(1'b0, sp && i == n - 1, 1'b0, 1'b0, d);
         chk("data ack", 16'(got_ack), 16'h0001);
         eq.push_back({cur, d});
         cur = nxt(cur);
      end
      chk("write count", 16'(wq.size()), 16'(n));
      foreach (eq[i]) chk("write", wq[i], eq[i]);
   endtask
   task automatic rd_seq(input logic [7:0] adr, p, input int n);
      rd_pulses = 0;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, adr);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, p);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, adr | 8'h01);
      chk("read address ack", 16'(got_ack), 16'h0001);
      chk("busy in read", 16'(busy), 16'h0001);
      cur = p;
      for (int i = 0; i < n; i++) begin
         xfer(1'b0, i == n - 1, 1'b1, i == n - 1, 8'h00);
         chk("read data", 16'(rd_data), 16'(rdat(cur)));
         cur = nxt(cur);
      end
      chk("read loads", 16'(rd_pulses), 16'(n));
   endtask
   // -------------------------------------------
   // main sequence
   // -------------------------------------------
   initial begin
      cur = 8'($urandom(16));
      repeat (20) @(negedge clock);
      for (int k = 0; k < 4; k++) begin
         {addr_strap_bit_high, addr_strap_bit_low} = 2'(k);
         // first pass releases the opening reset, later ones pulse it
         if (k > 0) begin
            rst_b = 1'b0;
            repeat (3) @(negedge clock);
         end
         rst_b = 1'b1;
         @(negedge clock);
         // straps are free pins again once latched
         {addr_strap_bit_high, addr_strap_bit_low} = 2'($urandom);
         wr_seq(sadr(2'(k)), ptrs[2*k], 3, 1'b1, 1'b0);
         wr_seq(sadr(2'(k)), ptrs[2*k+1], 2, 1'b0, k[0]);
         rd_seq(sadr(2'(k)), ptrs[2*k], 3);
         xfer(1'b1, 1'b0, 1'b0, 1'b0, sadr(2'(k + 1)));
         chk("foreign ack", 16'(got_ack), 16'h0000);
         wq.delete();
         xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h3C);
         chk("foreign data ack", 16'(got_ack), 16'h0000);
         chk("ignored writes", 16'(wq.size()), 16'h0000);
      end
      gc_pulses = 0;
      for (int j = 0; j < 3; j++) begin
         {addr_strap_bit_high, addr_strap_bit_low} = gns[j];
         xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
         chk("call ack", 16'(got_ack), 16'h0001);
         xfer(1'b0, 1'b1, 1'b0, 1'b0, gcb[j]);
         {addr_strap_bit_high, addr_strap_bit_low} = 2'($urandom);
         xfer(1'b1, 1'b1, 1'b0, 1'b0, sadr(gex[j]));
         chk("relatched ack", 16'(got_ack), 16'h0001);
         chk("soft resets", 16'(gc_pulses), 16'(j / 2));
         repeat (8) @(negedge clock);
         chk("idle after stop", 16'(busy), 16'h0000);
      end
      give_verdict();
   end
endmodule // tb_top
